//--- include/fsf_defs.svh
// offsets, field positions, reset values and clock ratios of the filter
`ifndef FSF_DEFS_SVH
`define FSF_DEFS_SVH
// register byte offsets
`define REG_MODE       8'h00
`define REG_STAT       8'h04
`define REG_DATA       8'h08
`define REG_CHAN       8'h0C
// mode register fields
`define MODE_RATE_LSB  0
`define MODE_RATE_W    10
`define MODE_SINC3_BIT 10
`define MODE_CHOP_BIT  11
`define MODE_SIXTY_BIT 12
`define MODE_AVG_LSB   13
`define MODE_USED_W    15
`define MODE_RST       32'h00000060
// channel register width
`define CHAN_W         3
// clock rates in kHz, master clock made by a phase accumulator
`define SYS_KHZ        16'd20000
`define MCLK_KHZ       16'd4920
// modulator runs at master clock / 2**4, sinc period is 2**10 x rate word
`define MOD_DIV_LOG2   4
`define SINC_BASE_LOG2 10
// result word width
`define RES_W          24
`endif

//--- include/fsf_pkg.sv
// types shared by the fast settling filter
package fsf_pkg;
  // averaging select codes, in code order 00..11
  typedef enum logic [1:0] {AVG_OFF, AVG_BY2, AVG_BY8, AVG_BY16} avg_sel_t;
  // conversion sequencer states
  typedef enum {ST_RESTART, ST_DISCARD, ST_ACCUM, ST_PUSH} conv_state_t;
endpackage

//--- testbench/fast_settle_filter_properties.sv
// bus and restart properties of the fast settling filter
`timescale 1ns/1ps
`include "fsf_defs.svh"
module fsf_checker
  import fsf_pkg::*;
(
  input wire logic               clk_sys,
  input wire logic               rstn,
  input wire logic [7:0]         paddr,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               mod_bit,
  input wire logic [`CHAN_W-1:0] chan_sel,
  input wire logic               mod_reset,
  input wire logic               result_ready
);
  logic [1:0] avg_q;                                          // last averaging code
  wire        mapped  = (paddr == `REG_MODE) || (paddr == `REG_STAT)
                        || (paddr == `REG_DATA) || (paddr == `REG_CHAN);
  wire        acc_one = psel && penable && !pready;           // first access cycle
  wire        wr_done = psel && penable && pready && pwrite;  // write lands here
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // mode tracking tells fast from normal channel handling
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      avg_q <= AVG_OFF;
    else if (wr_done && (paddr == `REG_MODE))
      avg_q <= pwdata[`MODE_AVG_LSB +: 2];
  end
  AST_ONE_WAIT: assert property (psel && !penable |-> ##2 pready)
    else $error("answer not two cycles after setup");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_IDLE_ZERO: assert property (!pready |-> (prdata == 32'h0))
    else $error("read data outside answer cycle");
  AST_UNMAPPED: assert property (acc_one && !mapped |=> pslverr && (prdata == 32'h0))
    else $error("unmapped access not refused");
  AST_MAPPED: assert property (acc_one && mapped |=> !pslverr)
    else $error("mapped access refused");
  AST_MODE_RESTART: assert property (wr_done && (paddr == `REG_MODE) |-> ##[1:2] mod_reset)
    else $error("mode write gave no restart");
  AST_NORMAL_CHAN: assert property (wr_done && (paddr == `REG_CHAN) && (avg_q == AVG_OFF)
    |-> ##[1:2] mod_reset)
    else $error("normal channel change gave no reset");
  AST_FAST_CHAN: assert property (wr_done && (paddr == `REG_CHAN) && (avg_q != AVG_OFF)
    |=> !mod_reset [*2])
    else $error("fast channel change reset the filter");
  AST_RESET_PULSE: assert property (mod_reset |=> !mod_reset)
    else $error("restart pulse too long");
endmodule // fsf_checker

bind fast_settle_filter fsf_checker u_chk (.clk_sys(clk_sys), .rstn(rstn), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .mod_bit(mod_bit), .chan_sel(chan_sel),
  .mod_reset(mod_reset), .result_ready(result_ready));

//--- testbench/mod_model.sv
// behavioural modulator giving a bit stream of fixed ones density
`timescale 1ns/1ps
module mod_model (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic mod_reset,
  output logic      mod_bit
);
  logic [3:0] phase_q;  // place in the density pattern
  // pattern restarts whenever the filter resets the modulator
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || mod_reset)
      phase_q <= 4'h0;
    else
      phase_q <= phase_q + 4'h1;
  end
  // twelve ones in sixteen, the stream never sits still
  assign mod_bit = (phase_q < 4'hC);
endmodule // mod_model

//--- testbench/testbench.sv
// self-checking bench for the fast settling filter
`timescale 1ns/1ps
`include "fsf_defs.svh"
module testbench
  import fsf_pkg::*;
;
  logic               clk_sys = 1'b0;   // 20 MHz system clock
  logic               rstn    = 1'b0;   // synchronous reset, active low
  logic [7:0]         paddr   = 8'h00;  // bus address
  logic               psel    = 1'b0;   // bus select
  logic               penable = 1'b0;   // bus access phase
  logic               pwrite  = 1'b0;   // bus direction
  logic [31:0]        pwdata  = 32'h0;  // bus write data
  logic [31:0]        prdata;           // bus read data
  logic               pready;           // bus answer
  logic               pslverr;          // bus refusal
  logic               mod_bit;          // modulator stream
  logic [`CHAN_W-1:0] chan_sel;         // channel in use
  logic               mod_reset;        // modulator restart
  logic               result_ready;     // result waiting
  logic [31:0]        rd;               // last read word
  logic               err;              // last refusal flag
  int                 mismatches = 0;   // failed comparisons
  int                 checked    = 0;   // comparisons made
  int                 cyc        = 0;   // clock cycle count
  int                 t0, t1, t2, c;    // times and loop index
  // clock and cycle counter
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  fast_settle_filter dut (.clk_sys(clk_sys), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mod_bit(mod_bit), .chan_sel(chan_sel), .mod_reset(mod_reset),
    .result_ready(result_ready));
  mod_model partner (.clk_sys(clk_sys), .rstn(rstn), .mod_reset(mod_reset), .mod_bit(mod_bit));
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if ((mismatches == 0) && (checked > 0))
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // one bus transfer, held until ready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge clk_sys);
      if (pready === 1'b1)
        break;
    end
    if (i == 16)
    begin
      mismatches++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // master clock ticks to system cycles
  function automatic int sys_cycles(input int ticks);
    return ticks * int'(`SYS_KHZ) / int'(`MCLK_KHZ);
  endfunction
  // a span of cycles lies in its window
  task automatic span(input int d, input int exp, input int lo, input int hi);
    check({31'h0, (d >= exp - lo) && (d <= exp + hi)}, 32'h1);
  endtask
  // wait for a result, note its cycle, pop it
  task automatic wait_result(output int t);
    int i;
    for (i = 0; i < 40000; i++)
    begin
      @(posedge clk_sys);
      if (result_ready === 1'b1)
        break;
    end
    if (i == 40000)
    begin
      mismatches++;
      conclude();
    end
    t = cyc;
    apb(1'b0, `REG_STAT, 32'h0);
    check(rd & 32'hFFFFFFFD, 32'h00000101);
    apb(1'b0, `REG_DATA, 32'h0);
    for (i = 0; (i < 8) && (result_ready !== 1'b0); i++)
      @(posedge clk_sys);
  endtask
  // main sequence
  initial
  begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    apb(1'b0, `REG_MODE, 32'h0);
    check(rd, `MODE_RST);
    apb(1'b0, `REG_STAT, 32'h0);
    check(rd, 32'h2);
    apb(1'b0, `REG_DATA, 32'h0);
    check(rd, 32'h0);
    check({29'h0, chan_sel}, 32'h0);
    apb(1'b1, 8'h14, 32'hFFFFFFFF);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b0, `REG_MODE, 32'h0);
    check(rd, `MODE_RST);
    $display("test reset_and_map done");
    for (c = 0; c < 4; c++)
    begin
      t0 = (c << `MODE_AVG_LSB) | (32'h1 << `MODE_SIXTY_BIT) | 32'h3FF;
      apb(1'b1, `REG_MODE, t0);
      apb(1'b0, `REG_MODE, 32'h0);
      check(rd, t0);
    end
    $display("test mode_codes done");
    apb(1'b1, `REG_MODE, (AVG_BY2 << `MODE_AVG_LSB) | 32'h1);
    t0 = cyc;
    wait_result(t1);
    span(t1 - t0, sys_cycles(5 * 1024), 4, 48);
    $display("test sinc4_avg2 done");
    apb(1'b1, `REG_MODE, (AVG_BY2 << `MODE_AVG_LSB) | (32'h1 << `MODE_SINC3_BIT)
      | (32'h1 << `MODE_SIXTY_BIT) | 32'h1);
    t0 = cyc;
    wait_result(t1);
    span(t1 - t0, sys_cycles(4 * 1024), 4, 48);
    apb(1'b1, `REG_CHAN, 32'h5);
    wait_result(t2);
    span(t2 - t1, sys_cycles(4 * 1024), 4, 4);
    check({29'h0, chan_sel}, 32'h5);
    $display("test sinc3_avg2_channel done");
    apb(1'b1, `REG_MODE, (32'h1 << `MODE_SINC3_BIT) | 32'h1);
    t0 = cyc;
    wait_result(t1);
    span(t1 - t0, sys_cycles(3 * 1024), 4, 48);
    wait_result(t2);
    span(t2 - t1, sys_cycles(1024), 4, 4);
    apb(1'b1, `REG_CHAN, 32'h2);
    repeat (2) @(posedge clk_sys);
    check({29'h0, chan_sel}, 32'h2);
    apb(1'b0, `REG_STAT, 32'h0);
    check(rd, 32'h2);
    $display("test normal_mode done");
    conclude();
  end
endmodule // testbench

//--- verilog/fast_settle_filter.sv
// sinc filter with averaging postfilter, apb registers and result fifo
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "fsf_defs.svh"

// Summary of operation
// - averaging code zero runs plain sinc output
// - fast mode averages 2, 8 or 16 sinc outputs
// - sinc4 period (4+avg-1) x 1024 x rate cycles
// - sinc3 period (3+avg-1) x 1024 x rate cycles
// - rate word is unsigned ten-bit value
// - fast mode result settles within one period without chop, two periods with chop
// - channel switch adds no delay in fast mode without chop
// - misaligned input step gives one unsettled result
// - chop keeps rate, settling takes two periods
// - sinc notch rate-based, postfilter notches divided
// - sixty hertz bit adds notch, keeps fifty
// - sinc4, rate 6, avg 16 gives 42.1 Hz
// - sinc4, rate 30, avg 16 gives 8.4 Hz
// - sixty hertz bit sits in mode register
// - normal mode channel change resets filter, resettles
module fast_settle_filter
  import fsf_pkg::*;
#(
  parameter int W          = 66,          // sinc word width
  parameter int RES_LSB    = 40,          // lowest averaged bit kept in result
  parameter int FIFO_DEPTH = 32           // result fifo depth
)(
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  input  wire logic [7:0]          paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                mod_bit,
  output logic [`CHAN_W-1:0]       chan_sel,
  output logic                     mod_reset,
  output logic                     result_ready
);
  localparam int A  = W + 5;              // accumulator width
  localparam int CW = $clog2(FIFO_DEPTH+1);
  if (RES_LSB + `RES_W > A) $error("result field exceeds accumulator");

  // averaging count minus one per select code
  function automatic logic [3:0] avg_last(input avg_sel_t s);
    case (s)
      AVG_BY2:  avg_last = 4'h1;
      AVG_BY8:  avg_last = 4'h7;
      AVG_BY16: avg_last = 4'hF;
      default:  avg_last = 4'h0;
    endcase
  endfunction

  // divide shift per select code
  function automatic int avg_shift(input avg_sel_t s);
    case (s)
      AVG_BY2:  avg_shift = 1;
      AVG_BY8:  avg_shift = 3;
      AVG_BY16: avg_shift = 4;
      default:  avg_shift = 0;
    endcase
  endfunction

  // ---------------- registers and bus state
  logic [31:0]         mode_q;            // mode register
  logic [`CHAN_W-1:0]  chan_next_q;       // channel written by software
  logic [`CHAN_W-1:0]  chan_sel_q;        // channel in use
  logic                pready_q;          // access phase answer
  logic                pslverr_q;         // unmapped address answer
  logic [31:0]         prdata_q;          // read data
  logic                mod_reset_q;       // modulator reset pulse
  logic                result_ready_q;    // fifo holds a result
  logic [15:0]         nco_q;             // master clock phase
  logic                mclk_en_q;         // master clock enable
  logic [19:0]         per_q;             // master clocks in sinc period
  logic                mod_meta_q;        // modulator bit sync stage 1
  logic                mod_sync_q;        // modulator bit sync stage 2
  conv_state_t         st_q;              // conversion sequencer
  logic [3:0]          cnt_q;             // sinc outputs in this phase
  logic signed [A-1:0] acc_q;             // postfilter sum
  logic signed [W-1:0] prev_q;            // previous sinc output
  logic signed [A-1:0] conv_prev_q;       // previous conversion, chop pair
  logic                pair_ok_q;         // previous conversion usable
  logic                chop_pol_q;        // input swap state
  logic [`RES_W-1:0]   res_q;             // result waiting for fifo

  // ---------------- mode fields
  wire [9:0]  rate_word = mode_q[`MODE_RATE_LSB +: `MODE_RATE_W];
  wire        rate_word_msb = rate_word[9];
  wire        rate_word_lsb = rate_word[0];
  wire        average_select_hi = mode_q[`MODE_AVG_LSB+1];
  wire        average_select_lo = mode_q[`MODE_AVG_LSB];
  wire        sixty_hz_notch_enable = mode_q[`MODE_SIXTY_BIT];
  wire        sinc3_sel = mode_q[`MODE_SINC3_BIT];
  wire        chop_en = mode_q[`MODE_CHOP_BIT];
  wire avg_sel_t avg_sel = avg_sel_t'({average_select_hi, average_select_lo});
  wire        fast = (avg_sel != AVG_OFF);
  wire        chop_on = chop_en & fast;

  // zero rate word is served as one
  wire [9:0]  rate_eff = (rate_word == 10'h000) ? 10'h001 : rate_word;
  // unsigned word times 1024 master clocks per sinc output
  wire [19:0] period_last = {rate_eff, {`SINC_BASE_LOG2{1'b0}}} - 20'h00001;

  // ---------------- bus decode
  wire        access   = psel & penable & pready_q;
  wire        hit_mode = (paddr == `REG_MODE);
  wire        hit_stat = (paddr == `REG_STAT);
  wire        hit_data = (paddr == `REG_DATA);
  wire        hit_chan = (paddr == `REG_CHAN);
  wire        mapped   = hit_mode | hit_stat | hit_data | hit_chan;
  wire        wr_mode  = access & pwrite & hit_mode;
  wire        wr_chan  = access & pwrite & hit_chan;
  // normal mode channel change and any mode write restart the filter
  wire        restart_req = wr_mode | (wr_chan & ~fast);

  // ---------------- fifo hookup
  logic                fifo_wr_ready;
  logic                fifo_rd_valid;
  logic [`RES_W-1:0]   fifo_rd_data;
  logic [CW-1:0]       fifo_count;
  wire                 fifo_wr_valid = (st_q == ST_PUSH);
  wire                 fifo_pop = access & ~pwrite & hit_data & fifo_rd_valid;

  // ---------------- read mux
  logic [31:0] rd_word;
  always_comb
  begin
    rd_word = 32'h00000000;
    if (hit_mode)
      rd_word = {{(32-`MODE_USED_W){1'b0}}, mode_q[`MODE_USED_W-1:0]};
    else if (hit_stat)
      rd_word = {{(24-CW){1'b0}}, fifo_count, 6'h00,
                 (st_q == ST_DISCARD), fifo_rd_valid};
    else if (hit_data)
      rd_word = fifo_rd_valid ? {{(32-`RES_W){1'b0}}, fifo_rd_data} : 32'h00000000;
    else if (hit_chan)
      rd_word = {{(32-`CHAN_W){1'b0}}, chan_next_q};
  end

  // ---------------- timing strobes
  wire [15:0] nco_sum = nco_q + `MCLK_KHZ;
  wire        nco_hit = (nco_sum >= `SYS_KHZ);
  wire        mod_en  = mclk_en_q & (per_q[`MOD_DIV_LOG2-1:0] == '1);
  wire        dec_en  = mclk_en_q & (per_q == period_last);

  // ---------------- sinc stage
  logic signed [W-1:0] sinc_out;
  logic                sinc_valid;
  wire                 sinc_clear = (st_q == ST_RESTART);

  sinc_core #(.W(W)) u_sinc (
    .clk_sys     (clk_sys),
    .rstn        (rstn),
    .clear       (sinc_clear),
    .mod_en      (mod_en),
    .mod_bit     (mod_sync_q ^ chop_pol_q),
    .dec_en      (dec_en),
    .third_order (sinc3_sel),
    .out_q       (sinc_out),
    .out_valid_q (sinc_valid)
  );

  // ---------------- postfilter arithmetic
  // with the sixty hertz bit each term is a two-tap mean of sinc outputs
  wire signed [W:0]   pair_term = ($signed({sinc_out[W-1], sinc_out})
                                 + $signed({prev_q[W-1], prev_q})) >>> 1;
  wire signed [W:0]   one_term  = $signed({sinc_out[W-1], sinc_out});
  wire signed [W:0]   term      = sixty_hz_notch_enable ? pair_term : one_term;
  wire signed [A-1:0] acc_d     = acc_q + A'(term);
  wire signed [A-1:0] conv      = acc_d >>> avg_shift(avg_sel);
  // chop mean of two opposite-polarity conversions
  wire signed [A:0]   chop_sum  = $signed({conv[A-1], conv})
                                + $signed({conv_prev_q[A-1], conv_prev_q});
  wire signed [A-1:0] chop_mean = A'(chop_sum >>> 1);
  wire signed [A-1:0] final_val = chop_on ? chop_mean : conv;
  wire [`RES_W-1:0]   res_word  = final_val[RES_LSB +: `RES_W];
  // discard the outputs before the sinc has filled
  wire [3:0]          discard_last = sinc3_sel ? 4'h1 : 4'h2;
  wire [3:0]          accum_last   = avg_last(avg_sel);
  wire                last_term    = (cnt_q == accum_last);
  wire                need_pair    = chop_on & ~pair_ok_q;

  sample_fifo #(.WIDTH(`RES_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys  (clk_sys),
    .rstn     (rstn),
    .wr_valid (fifo_wr_valid),
    .wr_ready (fifo_wr_ready),
    .wr_data  (res_q),
    .rd_valid (fifo_rd_valid),
    .rd_ready (fifo_pop),
    .rd_data  (fifo_rd_data),
    .count    (fifo_count)
  );

  // ---------------- apb slave, one wait state per access
  always_ff @(posedge clk_sys)
    if (!rstn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
    end
    else
    begin
      pready_q  <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & ~mapped;
      prdata_q  <= (psel & penable & ~pready_q & ~pwrite) ? rd_word : 32'h00000000;
    end

  // ---------------- software registers
  always_ff @(posedge clk_sys)
    if (!rstn)
    begin
      mode_q      <= `MODE_RST;
      chan_next_q <= '0;
      mod_reset_q <= 1'b0;
    end
    else
    begin
      if (wr_mode)
        mode_q <= {{(32-`MODE_USED_W){1'b0}}, pwdata[`MODE_USED_W-1:0]};
      if (wr_chan)
        chan_next_q <= pwdata[`CHAN_W-1:0];
      mod_reset_q <= restart_req;
    end

  // ---------------- master clock phase accumulator
  always_ff @(posedge clk_sys)
    if (!rstn)
    begin
      nco_q     <= 16'h0000;
      mclk_en_q <= 1'b0;
    end
    else
    begin
      nco_q     <= nco_hit ? nco_sum - `SYS_KHZ : nco_sum;
      mclk_en_q <= nco_hit;
    end

  // ---------------- sinc period counter, free running between restarts
  always_ff @(posedge clk_sys)
    if (!rstn || restart_req)
      per_q <= 20'h00000;
    else if (dec_en)
      per_q <= 20'h00000;
    else if (mclk_en_q)
      per_q <= per_q + 20'h00001;

  // ---------------- modulator bit synchroniser
  always_ff @(posedge clk_sys)
    if (!rstn)
    begin
      mod_meta_q <= 1'b0;
      mod_sync_q <= 1'b0;
    end
    else
    begin
      mod_meta_q <= mod_bit;
      mod_sync_q <= mod_meta_q;
    end

  // ---------------- conversion sequencer
  always_ff @(posedge clk_sys)
    if (!rstn)
    begin
      st_q        <= ST_RESTART;
      cnt_q       <= 4'h0;
      acc_q       <= '0;
      prev_q      <= '0;
      conv_prev_q <= '0;
      pair_ok_q   <= 1'b0;
      chop_pol_q  <= 1'b0;
      chan_sel_q  <= '0;
      res_q       <= '0;
    end
    else if (restart_req)
    begin
      // abort and resettle from scratch
      st_q      <= ST_RESTART;
      pair_ok_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        ST_RESTART:
        begin
          // sinc is cleared this cycle, new channel takes effect here
          cnt_q      <= 4'h0;
          acc_q      <= '0;
          chan_sel_q <= chan_next_q;
          if (chan_next_q != chan_sel_q)
            pair_ok_q <= 1'b0;
          if (chop_on)
            chop_pol_q <= ~chop_pol_q;
          else
            chop_pol_q <= 1'b0;
          st_q <= ST_DISCARD;
        end
        ST_DISCARD:
        begin
          // skip the sinc fill, keep the last one for the two-tap mean
          if (sinc_valid)
          begin
            prev_q <= sinc_out;
            if (cnt_q == discard_last)
            begin
              cnt_q <= 4'h0;
              st_q  <= ST_ACCUM;
            end
            else
              cnt_q <= cnt_q + 4'h1;
          end
        end
        ST_ACCUM:
        begin
          // sum the averaging window, plain mode uses a window of one
          if (sinc_valid)
          begin
            prev_q <= sinc_out;
            if (last_term)
            begin
              conv_prev_q <= conv;
              pair_ok_q   <= 1'b1;
              cnt_q       <= 4'h0;
              acc_q       <= '0;
              if (need_pair)
                st_q <= ST_RESTART;
              else
              begin
                res_q <= res_word;
                st_q  <= ST_PUSH;
              end
            end
            else
            begin
              acc_q <= acc_d;
              cnt_q <= cnt_q + 4'h1;
            end
          end
        end
        ST_PUSH:
        begin
          // stall here while the fifo is full
          if (fifo_wr_ready)
            st_q <= fast ? ST_RESTART : ST_ACCUM;
        end
        default:
          st_q <= ST_RESTART;
      endcase
    end

  // ---------------- registered outputs
  always_ff @(posedge clk_sys)
    if (!rstn)
      result_ready_q <= 1'b0;
    else
      result_ready_q <= (fifo_count > CW'(1)) | (fifo_rd_valid & ~fifo_pop)
                      | fifo_wr_valid & fifo_wr_ready;

  assign prdata       = prdata_q;
  assign pready       = pready_q;
  assign pslverr      = pslverr_q;
  assign chan_sel     = chan_sel_q;
  assign mod_reset    = mod_reset_q;
  assign result_ready = result_ready_q;
endmodule // fast_settle_filter

//--- verilog/sample_fifo.sv
// result fifo with valid and ready on both sides
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
)(
  input  wire logic                       clk_sys,
  input  wire logic                       rstn,
  input  wire logic                       wr_valid,
  output logic                            wr_ready,
  input  wire logic [WIDTH-1:0]           wr_data,
  output logic                            rd_valid,
  input  wire logic                       rd_ready,
  output logic [WIDTH-1:0]                rd_data,
  output logic [$clog2(DEPTH+1)-1:0]      count
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");

  logic [WIDTH-1:0] mem [DEPTH];          // storage
  logic [AW-1:0]    wp_q;                 // write pointer
  logic [AW-1:0]    rp_q;                 // read pointer
  logic [AW:0]      cnt_q;                // fill level
  wire              push = wr_valid & wr_ready;
  wire              pop  = rd_valid & rd_ready;

  // honest full and empty from the fill level
  assign wr_ready = (cnt_q != (AW+1)'(DEPTH));
  assign rd_valid = (cnt_q != '0);
  assign rd_data  = mem[rp_q];
  assign count    = cnt_q;

  // storage write, no reset needed
  always_ff @(posedge clk_sys)
    if (push)
      mem[wp_q] <= wr_data;

  // pointers and level
  always_ff @(posedge clk_sys)
    if (!rstn)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop)  rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
endmodule // sample_fifo

//--- verilog/sinc_core.sv
// third or fourth order sinc decimator on the modulator bit stream
`timescale 1ns/1ps
module sinc_core #(
  parameter int W = 66
)(
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  input  wire logic                clear,
  input  wire logic                mod_en,
  input  wire logic                mod_bit,
  input  wire logic                dec_en,
  input  wire logic                third_order,
  output logic signed [W-1:0]      out_q,
  output logic                     out_valid_q
);
  if (W < 66) $error("sinc word too narrow for order four at full decimation");

  logic signed [W-1:0] integ_q [4];        // integrator chain
  logic signed [W-1:0] dly_q   [4];        // comb delay taps
  logic signed [W-1:0] comb    [5];        // comb chain values
  wire  signed [W-1:0] x = mod_bit ? W'(1) : -W'(1);

  // comb chain, input taken from third or fourth integrator
  always_comb
  begin
    comb[0] = third_order ? integ_q[2] : integ_q[3];
    for (int k = 0; k < 4; k++)
      comb[k+1] = comb[k] - dly_q[k];
  end

  // integrators at modulator rate, combs at decimated rate
  always_ff @(posedge clk_sys)
    if (!rstn || clear)
    begin
      for (int k = 0; k < 4; k++)
      begin
        integ_q[k] <= '0;
        dly_q[k]   <= '0;
      end
      out_q       <= '0;
      out_valid_q <= 1'b0;
    end
    else
    begin
      out_valid_q <= dec_en;
      if (mod_en)
      begin
        integ_q[0] <= integ_q[0] + x;
        for (int k = 1; k < 4; k++)
          integ_q[k] <= integ_q[k] + integ_q[k-1];
      end
      if (dec_en)
      begin
        for (int k = 0; k < 4; k++)
          dly_q[k] <= comb[k];
        out_q <= third_order ? comb[3] : comb[4];
      end
    end
endmodule // sinc_core
